// >>> core/plt_pkg.sv
// package for the protocol linked timer: register map, fields, reset values
// assumes a 32-bit apb slave port; registers hold 8 bits in the low lanes
package plt_pkg;
   // ----------------------------------------
   // register offsets (byte addresses = index * 4)
   // ----------------------------------------
   localparam logic [7:0] TIMER_MODE_IDX = 8'h2A;
   localparam logic [7:0] PRESCALE_IDX = 8'h2B;
   localparam logic [7:0] RELOAD_HI_IDX = 8'h2C;
   localparam logic [7:0] RELOAD_LO_IDX = 8'h2D;
   localparam logic [7:0] COUNT_HI_IDX = 8'h2E;
   localparam logic [7:0] COUNT_LO_IDX = 8'h2F;
   localparam logic [7:0] CONTROL_IDX = 8'h30;
   localparam logic [7:0] STATUS_IDX = 8'h31;
   localparam logic [7:0] IRQ_STATUS_IDX = 8'h32;
   localparam logic [7:0] IRQ_MASK_IDX = 8'h33;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int AUTO_START_BIT = 7;
   localparam int GATE_SEL_LSB = 5;
   localparam int AUTO_RELOAD_BIT = 4;
   localparam int STOP_NOW_BIT = 0;
   localparam int START_NOW_BIT = 1;
   localparam int EVEN_DIV_BIT = 2;
   localparam int MULTI_FRAME_BIT = 3;
   localparam int RUNNING_BIT = 0;
   localparam int IRQ_ZERO_BIT = 0;
   localparam int IRQ_START_BIT = 1;
   localparam int IRQ_STOP_BIT = 2;
   localparam int IRQ_W = 3;
   // ----------------------------------------
   // reset values and counts
   // ----------------------------------------
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [11:0] PRESCALE_RESET = 12'h000;
   localparam logic [3:0] RX_STOP_BITS = 4'h5;
   // gate source codes
   localparam logic [1:0] GATE_NONE = 2'b00;
   localparam logic [1:0] GATE_PIN = 2'b01;
   localparam logic [1:0] GATE_AUX = 2'b10;
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_RUN = 3'b010,
      ST_DONE = 3'b100
   } plt_state_t;
endpackage

// >>> core/plt_prescaler.sv
// tick divider for the timer: one pulse every 2*p+1 or 2*p+2 clocks
// assumes clear is pulsed on each timer start so the first tick is a full period
`timescale 1ns/1ps
module plt_prescaler
(
   input wire logic clk,
   input wire logic rst,
   input wire logic clear,
   input wire logic enable,
   input wire logic [11:0] prescale,
   input wire logic evenDiv,
   output logic tick
);
   import plt_pkg::*;
   logic [12:0] div_r;
   logic [12:0] lastCount;
   logic atLast;
   // period minus one: 2p for odd divide, 2p+1 for even divide
   assign lastCount = {prescale, evenDiv};
   assign atLast = (div_r == lastCount);
   always_ff @(posedge clk)
   begin
      if (rst || clear)
      begin
         div_r <= 13'h0000;
         tick <= 1'b0;
      end
      else if (enable)
      begin
         div_r <= atLast ? 13'h0000 : div_r + 13'h0001;
         tick <= atLast;
      end
      else
      begin
         tick <= 1'b0;
      end
   end
endmodule

// >>> core/plt_timer.sv
// protocol linked count-down timer with apb register access and one irq line
// assumes txEnd and rxBit are one-cycle pulses from same-clock protocol logic;
// gate pins are asynchronous and are synchronised here
`timescale 1ns/1ps
module plt_timer
(
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic txEnd,
   input wire logic rxBit,
   input wire logic rxFrameStart,
   input wire logic gateInputPin,
   input wire logic auxiliaryPinOne,
   output logic timerRunningFlag,
   output logic timerZeroIrqFlag,
   output logic irq
);
   import plt_pkg::*;
   // ----------------------------------------
   // decode helper
   // ----------------------------------------
   function automatic logic hitReg(input logic [11:0] addr, input logic [7:0] idx);
      hitReg = (addr == {2'b00, idx, 2'b00});
   endfunction
   // ----------------------------------------
   // registers and state
   // ----------------------------------------
   logic [7:0] timerMode_r;
   logic [7:0] prescaleLow_r;
   logic [7:0] reloadHi_r;
   logic [7:0] reloadLo_r;
   logic [7:0] control_r;
   logic [15:0] count_r;
   logic [15:0] count_nxt;
   logic [IRQ_W-1:0] irqStatus_r;
   logic [IRQ_W-1:0] irqStatus_nxt;
   logic [IRQ_W-1:0] irqMask_r;
   logic [3:0] rxBits_r;
   plt_state_t state_r;
   plt_state_t state_nxt;
   logic gatePinMeta_r;
   logic gatePinSync_r;
   logic auxPinMeta_r;
   logic auxPinSync_r;
   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   wire access = psel && penable;
   // a write lands only at the edge where the master samples ready
   wire wrEn = access && pwrite && pready;
   wire wrMode = wrEn && hitReg(paddr, TIMER_MODE_IDX);
   wire wrPre = wrEn && hitReg(paddr, PRESCALE_IDX);
   wire wrRelHi = wrEn && hitReg(paddr, RELOAD_HI_IDX);
   wire wrRelLo = wrEn && hitReg(paddr, RELOAD_LO_IDX);
   wire wrCtrl = wrEn && hitReg(paddr, CONTROL_IDX);
   wire wrIrqSt = wrEn && hitReg(paddr, IRQ_STATUS_IDX);
   wire wrIrqMk = wrEn && hitReg(paddr, IRQ_MASK_IDX);
   wire mapped = hitReg(paddr, TIMER_MODE_IDX) || hitReg(paddr, PRESCALE_IDX)
      || hitReg(paddr, RELOAD_HI_IDX) || hitReg(paddr, RELOAD_LO_IDX)
      || hitReg(paddr, COUNT_HI_IDX) || hitReg(paddr, COUNT_LO_IDX)
      || hitReg(paddr, CONTROL_IDX) || hitReg(paddr, STATUS_IDX)
      || hitReg(paddr, IRQ_STATUS_IDX) || hitReg(paddr, IRQ_MASK_IDX);
   // ----------------------------------------
   // mode fields
   // ----------------------------------------
   wire autoStartEnable = timerMode_r[AUTO_START_BIT];
   wire [1:0] gateSourceSelect = timerMode_r[GATE_SEL_LSB +: 2];
   wire autoReloadEnable = timerMode_r[AUTO_RELOAD_BIT];
   wire [11:0] prescaleValue = {timerMode_r[3:0], prescaleLow_r};
   wire evenDivideSelect = control_r[EVEN_DIV_BIT];
   wire multiFrameReceive = control_r[MULTI_FRAME_BIT];
   wire [15:0] reloadValue = {reloadHi_r, reloadLo_r};
   // stop-now and start-now are self-clearing strobes, never stored
   wire stopNow = wrCtrl && pwdata[STOP_NOW_BIT];
   wire startNow = wrCtrl && pwdata[START_NOW_BIT];
   // ----------------------------------------
   // gating: code 11 treated as never enabled
   // ----------------------------------------
   wire gateOpen = (gateSourceSelect == GATE_NONE)
      || (gateSourceSelect == GATE_PIN && gatePinSync_r)
      || (gateSourceSelect == GATE_AUX && auxPinSync_r);
   // ----------------------------------------
   // protocol events
   // ----------------------------------------
   wire autoStart = autoStartEnable && txEnd;
   wire fifthBit = rxBit && (rxBits_r == RX_STOP_BITS - 4'h1);
   wire autoStop = autoStartEnable && !multiFrameReceive && fifthBit;
   wire startEv = autoStart || startNow;
   wire running = (state_r == ST_RUN);
   logic tick;
   plt_prescaler prescaler
   (
      .clk(clk),
      .rst(rst),
      .clear(startEv),
      .enable(running && gateOpen),
      .prescale(prescaleValue),
      .evenDiv(evenDivideSelect),
      .tick(tick)
   );
   // ----------------------------------------
   // next state and count
   // ----------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      count_nxt = count_r;
      irqStatus_nxt = irqStatus_r;
      if (wrIrqSt)
      begin
         irqStatus_nxt = irqStatus_r & ~pwdata[IRQ_W-1:0];
      end
      if (stopNow || autoStop)
      begin
         state_nxt = ST_IDLE;
         if (running)
         begin
            irqStatus_nxt[IRQ_STOP_BIT] = 1'b1;
         end
      end
      else if (startEv)
      begin
         state_nxt = ST_RUN;
         count_nxt = reloadValue;
         irqStatus_nxt[IRQ_START_BIT] = 1'b1;
      end
      else if (running && tick)
      begin
         if (count_r == COUNT_RESET)
         begin
            irqStatus_nxt[IRQ_ZERO_BIT] = 1'b1;
            if (autoReloadEnable)
            begin
               count_nxt = reloadValue;
            end
            else
            begin
               state_nxt = ST_DONE;
            end
         end
         else
         begin
            count_nxt = count_r - 16'h0001;
         end
      end
   end
   // ----------------------------------------
   // read mux
   // ----------------------------------------
   logic [7:0] rdByte;
   always_comb
   begin
      case (1'b1)
         hitReg(paddr, TIMER_MODE_IDX): rdByte = timerMode_r;
         hitReg(paddr, PRESCALE_IDX): rdByte = prescaleLow_r;
         hitReg(paddr, RELOAD_HI_IDX): rdByte = reloadHi_r;
         hitReg(paddr, RELOAD_LO_IDX): rdByte = reloadLo_r;
         hitReg(paddr, COUNT_HI_IDX): rdByte = count_r[15:8];
         hitReg(paddr, COUNT_LO_IDX): rdByte = count_r[7:0];
         hitReg(paddr, CONTROL_IDX): rdByte = control_r;
         hitReg(paddr, STATUS_IDX): rdByte = {7'h00, timerRunningFlag};
         hitReg(paddr, IRQ_STATUS_IDX): rdByte = {5'h00, irqStatus_r};
         hitReg(paddr, IRQ_MASK_IDX): rdByte = {5'h00, irqMask_r};
         default: rdByte = 8'h00;
      endcase
   end
   // ----------------------------------------
   // gate pin synchronisers
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      gatePinMeta_r <= gateInputPin;
      gatePinSync_r <= gatePinMeta_r;
      auxPinMeta_r <= auxiliaryPinOne;
      auxPinSync_r <= auxPinMeta_r;
   end
   // ----------------------------------------
   // host registers
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         timerMode_r <= REG_RESET;
         prescaleLow_r <= REG_RESET;
         reloadHi_r <= REG_RESET;
         reloadLo_r <= REG_RESET;
         control_r <= REG_RESET;
         irqMask_r <= '0;
      end
      else
      begin
         if (wrMode) timerMode_r <= pwdata[7:0];
         if (wrPre) prescaleLow_r <= pwdata[7:0];
         if (wrRelHi) reloadHi_r <= pwdata[7:0];
         if (wrRelLo) reloadLo_r <= pwdata[7:0];
         if (wrCtrl) control_r <= {4'h0, pwdata[MULTI_FRAME_BIT], pwdata[EVEN_DIV_BIT], 2'b00};
         if (wrIrqMk) irqMask_r <= pwdata[IRQ_W-1:0];
      end
   end
   // ----------------------------------------
   // timer core state
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_r <= ST_IDLE;
         count_r <= COUNT_RESET;
         irqStatus_r <= '0;
      end
      else
      begin
         state_r <= state_nxt;
         count_r <= count_nxt;
         irqStatus_r <= irqStatus_nxt;
      end
   end
   // received bits since the last timer start or frame start, saturating at the stop count
   always_ff @(posedge clk)
   begin
      if (rst || startEv || rxFrameStart)
      begin
         rxBits_r <= 4'h0;
      end
      else if (rxBit && rxBits_r != RX_STOP_BITS)
      begin
         rxBits_r <= rxBits_r + 4'h1;
      end
   end
   // ----------------------------------------
   // registered outputs and apb answer
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         timerRunningFlag <= 1'b0;
         timerZeroIrqFlag <= 1'b0;
         irq <= 1'b0;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         // gated: running only while the gate lets the count proceed
         timerRunningFlag <= (state_nxt == ST_RUN) && gateOpen;
         timerZeroIrqFlag <= irqStatus_nxt[IRQ_ZERO_BIT];
         irq <= |(irqStatus_nxt & irqMask_r);
         // one wait state keeps every output registered
         pready <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !mapped;
         prdata <= {24'h00_0000, rdByte};
      end
   end
endmodule

// >>> bench/plt_timer_sva.sv
// checker for the timer's bus answers, flags and irq line
// assumes it is bound onto plt_timer and sees only its ports
`timescale 1ns/1ps
module plt_timer_sva
(
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic timerRunningFlag,
   input wire logic timerZeroIrqFlag,
   input wire logic irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   wire wrAcc = psel && penable && pwrite;
   // control word sits at its index times four
   wire stopHit = wrAcc && paddr == {2'b00, plt_pkg::CONTROL_IDX, 2'b00}
      && pwdata[plt_pkg::STOP_NOW_BIT];
   sequence accBegin;
      psel && !penable ##1 psel && penable;
   endsequence
   a_one_wait: assert property (accBegin |=> pready)
      else $error("ready not after one wait");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("slverr without ready");
   a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h00_0000)
      else $error("read upper bits set");
   a_reset_quiet: assert property (disable iff (1'b0) rst |=> !pready && !irq && !timerRunningFlag)
      else $error("outputs active in reset");
   a_flag_sticky: assert property (timerZeroIrqFlag && !wrAcc && !$past(wrAcc) |=> timerZeroIrqFlag)
      else $error("zero flag lost");
   a_stop_halts: assert property (stopHit |-> ##[1:3] !timerRunningFlag)
      else $error("stop did not halt");
   a_zero_after_run: assert property ($rose(timerZeroIrqFlag) |->
      $past(timerRunningFlag) || $past(timerRunningFlag, 2) || $past(timerRunningFlag, 3))
      else $error("zero flag without run");
endmodule
bind plt_timer plt_timer_sva u_plt_timer_sva (.clk(clk), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .timerRunningFlag(timerRunningFlag),
   .timerZeroIrqFlag(timerZeroIrqFlag), .irq(irq));

// >>> bench/plt_proto_model.sv
// protocol side stand-in: end of transmission and received-bit pulses
// assumes the timer samples them on the rising edge
`timescale 1ns/1ps
module plt_proto_model
(
   input wire logic clk,
   output logic txEnd,
   output logic rxBit,
   output logic rxFrameStart
);
   initial
   begin
      txEnd = 1'b0;
      rxBit = 1'b0;
      rxFrameStart = 1'b0;
   end
   task automatic sendTx();
   begin
      @(posedge clk) txEnd <= 1'b1;
      @(posedge clk) txEnd <= 1'b0;
   end
   endtask
   // optional frame start, then n bits; gap+1 idle cycles after each bit gives slow senders
   task automatic sendRx(input logic fs, input int n, input int gap);
   begin
      @(posedge clk) rxFrameStart <= fs;
      @(posedge clk) rxFrameStart <= 1'b0;
      repeat (n)
      begin
         rxBit <= 1'b1;
         @(posedge clk) rxBit <= 1'b0;
         repeat (gap + 1) @(posedge clk);
      end
   end
   endtask
endmodule

// >>> bench/plt_timer_tb.sv
// self-checking bench for the protocol linked timer
// assumes one-wait-state apb answers and a 10 MHz clock
`timescale 1ns/1ps
module plt_timer_tb;
   import plt_pkg::*;
   logic clk, rst, psel, penable, pwrite, gatePin, auxPin, pready, pslverr, err;
   logic txEnd, rxBit, rxFrameStart, runFlag, zeroFlag, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int fails = 0;
   int checked = 0;
   int cyc = 0;
   int nOdd, nEven;
   plt_timer u_plt_timer (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .txEnd(txEnd), .rxBit(rxBit), .rxFrameStart(rxFrameStart),
      .gateInputPin(gatePin), .auxiliaryPinOne(auxPin), .timerRunningFlag(runFlag),
      .timerZeroIrqFlag(zeroFlag), .irq(irq));
   plt_proto_model u_plt_proto_model (.clk(clk), .txEnd(txEnd), .rxBit(rxBit),
      .rxFrameStart(rxFrameStart));
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 8000)
      begin
         fails++;
         conclude();
      end
   end
   task automatic conclude();
   begin
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
   begin
      checked++;
      if (g !== e)
      begin
         fails++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   end
   endtask
   task automatic settle();
   begin
      repeat (5) @(posedge clk);
   end
   endtask
   // waits for pready at each edge; a slower slave only costs cycles
   task automatic apb(input logic [7:0] idx, input logic wr, input logic [7:0] d);
   begin
      @(posedge clk);
      paddr <= {2'b00, idx, 2'b00};
      pwrite <= wr;
      pwdata <= {24'h00_0000, d};
      psel <= 1'b1;
      @(posedge clk) penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   end
   endtask
   task automatic rdChk(input string nm, input logic [7:0] idx, input logic [7:0] e);
   begin
      apb(idx, 1'b0, 8'h00);
      chk(nm, {24'h00_0000, e}, rd);
   end
   endtask
   task automatic runTo(input logic [7:0] ctl, output int n);
   begin
      apb(CONTROL_IDX, 1'b1, ctl);
      n = 0;
      while (zeroFlag !== 1'b1)
      begin
         @(posedge clk);
         n++;
      end
   end
   endtask
   task automatic tRegs();
   begin
      rdChk("mode", TIMER_MODE_IDX, 8'h00);
      apb(TIMER_MODE_IDX, 1'b1, 8'h6C);
      rdChk("mode rw", TIMER_MODE_IDX, 8'h6C);
      apb(8'h3F, 1'b0, 8'h00);
      chk("slverr", 1, err);
      apb(COUNT_LO_IDX, 1'b1, 8'h55);
      rdChk("count ro", COUNT_LO_IDX, 8'h00);
      $display("regs done");
   end
   endtask
   task automatic tCount();
   begin
      apb(TIMER_MODE_IDX, 1'b1, 8'h00);
      apb(PRESCALE_IDX, 1'b1, 8'h03);
      apb(RELOAD_LO_IDX, 1'b1, 8'h04);
      runTo(8'h02, nOdd);
      chk("odd period", 1, nOdd >= 33 && nOdd <= 40);
      rdChk("halted", STATUS_IDX, 8'h00);
      rdChk("count end", COUNT_LO_IDX, 8'h00);
      rdChk("irq status", IRQ_STATUS_IDX, 8'h03);
      chk("irq masked", 0, irq);
      apb(IRQ_MASK_IDX, 1'b1, 8'h01);
      settle();
      chk("irq on", 1, irq);
      apb(IRQ_STATUS_IDX, 1'b1, 8'h07);
      settle();
      chk("irq clear", 0, irq);
      chk("zero clear", 0, zeroFlag);
      runTo(8'h06, nEven);
      chk("even extra", 5, nEven - nOdd);
      apb(IRQ_STATUS_IDX, 1'b1, 8'h07);
      apb(TIMER_MODE_IDX, 1'b1, 8'h10);
      runTo(8'h02, nOdd);
      settle();
      chk("reloaded", 1, runFlag);
      apb(PRESCALE_IDX, 1'b1, 8'hFF);
      apb(RELOAD_HI_IDX, 1'b1, 8'h12);
      rdChk("no early", COUNT_HI_IDX, 8'h00);
      apb(CONTROL_IDX, 1'b1, 8'h02);
      rdChk("load hi", COUNT_HI_IDX, 8'h12);
      apb(CONTROL_IDX, 1'b1, 8'h01);
      settle();
      chk("stop now", 0, runFlag);
      rdChk("stop flag", STATUS_IDX, 8'h00);
      $display("count done");
   end
   endtask
   task automatic tProto();
   begin
      apb(IRQ_STATUS_IDX, 1'b1, 8'h07);
      apb(TIMER_MODE_IDX, 1'b1, 8'h80);
      u_plt_proto_model.sendTx();
      settle();
      chk("auto start", 1, runFlag);
      u_plt_proto_model.sendRx(1'b1, 4, 0);
      settle();
      chk("four bits", 1, runFlag);
      u_plt_proto_model.sendRx(1'b0, 1, 0);
      settle();
      chk("fifth bit", 0, runFlag);
      rdChk("rx stop irq", IRQ_STATUS_IDX, 8'h06);
      apb(CONTROL_IDX, 1'b1, 8'h08);
      u_plt_proto_model.sendTx();
      u_plt_proto_model.sendRx(1'b1, 6, 3);
      settle();
      chk("multi frame", 1, runFlag);
      apb(CONTROL_IDX, 1'b1, 8'h09);
      settle();
      chk("sw stop", 0, runFlag);
      apb(TIMER_MODE_IDX, 1'b1, 8'h00);
      u_plt_proto_model.sendTx();
      settle();
      chk("no auto", 0, runFlag);
      apb(CONTROL_IDX, 1'b1, 8'h02);
      u_plt_proto_model.sendRx(1'b1, 5, 0);
      settle();
      chk("rx ignored", 1, runFlag);
      apb(CONTROL_IDX, 1'b1, 8'h01);
      $display("proto done");
   end
   endtask
   task automatic tGate();
      logic e;
   begin
      for (int g = 0; g < 4; g++)
      begin
         apb(TIMER_MODE_IDX, 1'b1, 8'(g << 5));
         apb(CONTROL_IDX, 1'b1, 8'h02);
         for (int p = 0; p < 4; p++)
         begin
            gatePin <= p[0];
            auxPin <= p[1];
            settle();
            e = (g == 0) || (g == 1 && p[0]) || (g == 2 && p[1]);
            chk("gated run", e, runFlag);
         end
         apb(CONTROL_IDX, 1'b1, 8'h01);
      end
      $display("gate done");
   end
   endtask
   initial
   begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      gatePin = 1'b0;
      auxPin = 1'b0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      tRegs();
      tCount();
      tProto();
      tGate();
      conclude();
   end
endmodule
